// File: hw/ecs_pkg.sv
// package: constants and types for control-source selection
// Contract
// RQ1: commands come from exactly one chosen source: keypads, host or inputs
// RQ2: keypad source lets hand unit and panel command, with three lock levels
// RQ3: lock level one leaves every key on both keypads working
// RQ4: level two ignores cal, refuses basic menu, ext/service need password
// RQ5: level three ignores cal, range and zero keys; menus as level two
// RQ6: level three leaves only start, stop, vent and volume working
// RQ7: host source ignores all keypad function keys and refuses menu changes
// RQ8: input source takes start, stop and suppress from the discrete lines
// RQ9: a rising edge on the start line begins the start sequence
// RQ10: a rising stop edge stops measuring, or acknowledges a pending error
// RQ11: stop held high longer than the vent delay vents the test port
// RQ12: suppress line high holds the leak-rate reading at zero
// RQ13: suppress line low or open gives the full measurement signal
// RQ14: vent delay is zero, 1 s, 1.5 s or 2 s
// RQ15: stop released before the delay gives standby only, no vent
// RQ16: the no-vent setting never vents from stop key or stop line
// RQ17: discrete inputs are synchronised and edges found from two samples
// RQ18: a counter restarted on each stop rise raises vent past the delay
package ecs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
    localparam int unsigned CLK_KHZ      = CLK_FREQ_HZ / 1000;
    localparam int unsigned CNT_W        = 25;
    localparam int unsigned VENT_1_MS    = 1000;
    localparam int unsigned VENT_15_MS   = 1500;
    localparam int unsigned VENT_2_MS    = 2000;
    localparam logic [CNT_W-1:0] VENT_1_CYC  = CNT_W'(VENT_1_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] VENT_15_CYC = CNT_W'(VENT_15_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] VENT_2_CYC  = CNT_W'(VENT_2_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] CNT_RST     = 25'h0000000;

    ////////////////////////////////////////////////////////////////////////
    // control source, lock level, vent delay setting
    typedef enum logic [2:0] {
        SRC_KEYS = 3'b001,
        SRC_HOST = 3'b010,
        SRC_EXT  = 3'b100
    } ecs_src_t;

    typedef enum logic [1:0] {
        LOCK_1 = 2'h0,
        LOCK_2 = 2'h1,
        LOCK_3 = 2'h2
    } ecs_lock_t;

    typedef enum logic [2:0] {
        VENT_NOW   = 3'h0,
        VENT_1S    = 3'h1,
        VENT_15S   = 3'h2,
        VENT_2S    = 3'h3,
        VENT_NEVER = 3'h4
    } ecs_vent_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_DONE = 3'b100
    } ecs_stop_t;

    ////////////////////////////////////////////////////////////////////////
    // key positions and lock masks
    localparam int unsigned KEY_START  = 0;
    localparam int unsigned KEY_STOP   = 1;
    localparam int unsigned KEY_CAL    = 2;
    localparam int unsigned KEY_MANUAL = 3;
    localparam int unsigned KEY_ZERO   = 4;
    localparam int unsigned KEY_VOL_UP = 5;
    localparam int unsigned KEY_VOL_DN = 6;
    localparam int unsigned KEY_OTHER  = 7;
    localparam int unsigned KEY_N      = 8;
    localparam logic [KEY_N-1:0] MASK_L1 = 8'hff;
    localparam logic [KEY_N-1:0] MASK_L2 = 8'hfb;
    localparam logic [KEY_N-1:0] MASK_L3 = 8'h63;
    localparam logic [KEY_N-1:0] MASK_NONE = 8'h00;

    // menu classes
    localparam int unsigned MENU_BASIC = 0;
    localparam int unsigned MENU_EXT   = 1;
    localparam int unsigned MENU_SVC   = 2;
    localparam int unsigned MENU_N     = 3;

    // discrete input pins
    localparam int unsigned PIN_START = 0;
    localparam int unsigned PIN_STOP  = 1;
    localparam int unsigned PIN_ZERO  = 2;
    localparam int unsigned PIN_N     = 3;
    localparam logic [PIN_N-1:0] PIN_RST = 3'h0;

endpackage

// File: hw/ecs_ext_if.sv
// interface: conditioned discrete inputs between conditioner and core
`timescale 1ns/100ps
interface ecs_ext_if;
    logic start_rise;
    logic stop_rise;
    logic stop_lvl;
    logic zero_lvl;

    modport drv (
        output start_rise,
        output stop_rise,
        output stop_lvl,
        output zero_lvl
    );
    modport use_side (
        input  start_rise,
        input  stop_rise,
        input  stop_lvl,
        input  zero_lvl
    );
endinterface

// File: hw/ecs_in_cond.sv
// module: synchroniser and edge finder for the discrete inputs
`timescale 1ns/100ps
module ecs_in_cond
    import ecs_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [ecs_pkg::PIN_N-1:0] ext_pins,
    ecs_ext_if.drv                        ext
);

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] prev;
    } ecs_cond_st_t;

    ecs_cond_st_t q;
    ecs_cond_st_t d;
    logic [PIN_N-1:0] rise;

    ////////////////////////////////////////////////////////////////////////
    // two-stage sync, then one more stage as the previous sample
    always_comb begin
        d      = q;
        d.s1   = ext_pins;       // [RQ17]
        d.s2   = q.s1;           // [RQ17]
        d.prev = q.s2;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '{s1: PIN_RST, s2: PIN_RST, prev: PIN_RST};
        end else begin
            q <= d;
        end
    end

    // edge from two consecutive synchronised samples
    genvar i;
    generate
        for (i = 0; i < PIN_N; i++) begin : g_edge
            assign rise[i] = q.s2[i] & ~q.prev[i]; // [RQ17]
        end
    endgenerate

    assign ext.start_rise = rise[PIN_START];
    assign ext.stop_rise  = rise[PIN_STOP];
    assign ext.stop_lvl   = q.s2[PIN_STOP];
    assign ext.zero_lvl   = q.s2[PIN_ZERO];

endmodule

// File: hw/ecs_ctrl.sv
// module: control-source selection, key locks and stop/vent timing
`timescale 1ns/100ps
module ecs_ctrl #(
    parameter logic [ecs_pkg::CNT_W-1:0] VENT_1_CYC  = ecs_pkg::VENT_1_CYC,
    parameter logic [ecs_pkg::CNT_W-1:0] VENT_15_CYC = ecs_pkg::VENT_15_CYC,
    parameter logic [ecs_pkg::CNT_W-1:0] VENT_2_CYC  = ecs_pkg::VENT_2_CYC
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire ecs_pkg::ecs_src_t         src_sel,
    input  wire ecs_pkg::ecs_lock_t        lock_lvl,
    input  wire ecs_pkg::ecs_vent_t        vent_sel,
    input  wire logic [ecs_pkg::KEY_N-1:0]  hand_keys,
    input  wire logic [ecs_pkg::KEY_N-1:0]  panel_keys,
    input  wire logic [ecs_pkg::MENU_N-1:0] menu_req,
    input  wire logic                      pwd_ok,
    input  wire logic                      host_start,
    input  wire logic                      host_stop,
    input  wire logic                      host_zero,
    input  wire logic                      host_vent,
    input  wire logic                      ext_start_pin,
    input  wire logic                      ext_stop_pin,
    input  wire logic                      ext_zero_pin,
    input  wire logic                      err_pending,
    output logic                           cmd_start,
    output logic                           cmd_stop,
    output logic                           cmd_ack,
    output logic                           cmd_vent,
    output logic                           cmd_cal,
    output logic                           cmd_manual,
    output logic                           cmd_zero,
    output logic                           vol_up,
    output logic                           vol_dn,
    output logic                           key_other,
    output logic                           bg_suppress,
    output logic [ecs_pkg::MENU_N-1:0]      menu_grant,
    output logic [ecs_pkg::MENU_N-1:0]      menu_refuse,
    output logic                           stop_held
);
    import ecs_pkg::*;

    typedef struct packed {
        ecs_stop_t         st;
        logic [CNT_W-1:0]  cnt;
        logic              key_stop_prev;
        logic              start;
        logic              stop;
        logic              ack;
        logic              vent;
        logic              cal;
        logic              manual;
        logic              zero;
        logic              up;
        logic              dn;
        logic              other;
        logic              bg;
        logic [MENU_N-1:0] grant;
        logic [MENU_N-1:0] refuse;
    } ecs_ctrl_st_t;

    localparam ecs_ctrl_st_t RST_ST = '{
        st: ST_IDLE, cnt: CNT_RST, grant: 3'h0, refuse: 3'h0, default: 1'b0
    };

    ecs_ctrl_st_t q;
    ecs_ctrl_st_t d;
    ecs_ext_if    ext ();

    logic [KEY_N-1:0] keys;
    logic [KEY_N-1:0] kmask;
    logic [KEY_N-1:0] kgo;
    logic             stop_lvl;
    logic             stop_rise;
    logic             is_keys;
    logic             is_host;
    logic             is_ext;
    logic             vent_ok;
    logic [CNT_W-1:0] lim;

    ////////////////////////////////////////////////////////////////////////
    // input conditioning for the connector lines
    ecs_in_cond u_cond (
        .core_clk (core_clk),
        .rst      (rst),
        .ext_pins ({ext_zero_pin, ext_stop_pin, ext_start_pin}),
        .ext      (ext.drv)
    );

    ////////////////////////////////////////////////////////////////////////
    // key permission from source and lock level
    function automatic logic [KEY_N-1:0] key_mask(ecs_src_t s, ecs_lock_t l);
        logic [KEY_N-1:0] m;
        m = MASK_NONE;
        if (s == SRC_KEYS) begin
            unique case (l)
                LOCK_1:  m = MASK_L1;
                LOCK_2:  m = MASK_L2;
                LOCK_3:  m = MASK_L3;
                default: m = MASK_L3;  // unknown code: strictest lock
            endcase
        end
        return m;
    endfunction

    // source decode; only one source acts at a time
    assign is_keys = (src_sel == SRC_KEYS);         // [RQ1]
    assign is_host = (src_sel == SRC_HOST);         // [RQ1]
    assign is_ext  = (src_sel == SRC_EXT);          // [RQ1]

    // both keypads merged, then gated by the lock
    assign keys  = hand_keys | panel_keys;          // [RQ2]
    assign kmask = key_mask(src_sel, lock_lvl);     // [RQ3] [RQ4] [RQ5] [RQ7]
    assign kgo   = keys & kmask;                    // [RQ6]

    // stop level and edge from the external line or the keypad, whichever is selected; none under host
    always_comb begin
        stop_lvl  = 1'b0;
        stop_rise = 1'b0;
        if (is_ext) begin
            stop_lvl  = ext.stop_lvl;               // [RQ8]
            stop_rise = ext.stop_rise;              // [RQ10]
        end else if (is_keys) begin
            stop_lvl  = kgo[KEY_STOP];
            stop_rise = kgo[KEY_STOP] & ~q.key_stop_prev;
        end
    end

    // vent delay decode
    always_comb begin
        lim     = CNT_RST;
        vent_ok = 1'b1;
        unique case (vent_sel)
            VENT_NOW:   lim = CNT_RST;              // [RQ14]
            VENT_1S:    lim = VENT_1_CYC;           // [RQ14]
            VENT_15S:   lim = VENT_15_CYC;          // [RQ14]
            VENT_2S:    lim = VENT_2_CYC;           // [RQ14]
            default:    vent_ok = 1'b0;             // [RQ16]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: commands and stop/vent timing
    always_comb begin
        d               = q;
        d.key_stop_prev = kgo[KEY_STOP];
        d.vent          = is_host & host_vent;

        // start from the selected source only
        d.start = is_ext  ? ext.start_rise :        // [RQ9]
                  is_host ? host_start : kgo[KEY_START];

        // stop edge stops, or acknowledges an error instead
        d.stop = (stop_rise | (is_host & host_stop)) & ~err_pending; // [RQ10]
        d.ack  = (stop_rise | (is_host & host_stop)) & err_pending;  // [RQ10]

        // keypad function outputs
        d.cal    = kgo[KEY_CAL];
        d.manual = kgo[KEY_MANUAL];
        d.zero   = kgo[KEY_ZERO] | (is_host & host_zero);
        d.up     = kgo[KEY_VOL_UP];
        d.dn     = kgo[KEY_VOL_DN];
        d.other  = kgo[KEY_OTHER];

        // suppress follows the line level, low when open
        d.bg = is_ext & ext.zero_lvl;               // [RQ12] [RQ13]

        // menu access: free at level one, ext/service by password above, none otherwise
        d.grant = 3'h0;
        if (is_keys) begin
            if (lock_lvl == LOCK_1) begin
                d.grant = menu_req;                 // [RQ3]
            end else if (pwd_ok) begin
                d.grant[MENU_EXT] = menu_req[MENU_EXT]; // [RQ4] [RQ5]
                d.grant[MENU_SVC] = menu_req[MENU_SVC]; // [RQ4] [RQ5]
            end
        end
        d.refuse = menu_req & ~d.grant;             // [RQ7]

        // stop hold timer; counter restarts on each rising edge
        unique case (q.st)
            ST_IDLE: begin
                if (stop_rise) begin
                    d.cnt = CNT_W'(1);              // [RQ18]
                    if (!vent_ok) begin
                        d.st = ST_DONE;             // [RQ16]
                    end else if (lim == CNT_RST) begin
                        d.vent = 1'b1;              // [RQ14]
                        d.st   = ST_DONE;
                    end else begin
                        d.st = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (!stop_lvl) begin
                    d.st = ST_IDLE;                 // [RQ15]
                end else if (!vent_ok) begin
                    d.st = ST_DONE;                 // [RQ16]
                end else if (q.cnt >= lim) begin
                    d.vent = 1'b1;                  // [RQ11] [RQ18]
                    d.st   = ST_DONE;
                end else begin
                    d.cnt = CNT_W'(q.cnt + 1'b1);   // [RQ18]
                end
            end
            ST_DONE: begin
                if (!stop_lvl) begin
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= RST_ST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops
    assign cmd_start   = q.start;
    assign cmd_stop    = q.stop;
    assign cmd_ack     = q.ack;
    assign cmd_vent    = q.vent;
    assign cmd_cal     = q.cal;
    assign cmd_manual  = q.manual;
    assign cmd_zero    = q.zero;
    assign vol_up      = q.up;
    assign vol_dn      = q.dn;
    assign key_other   = q.other;
    assign bg_suppress = q.bg;
    assign menu_grant  = q.grant;
    assign menu_refuse = q.refuse;
    assign stop_held   = (q.st == ST_HOLD);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    host_keys_off_a: assert property ( // [RQ7]
        is_host |=> !(cmd_cal || cmd_manual || key_other || vol_up || vol_dn)
                    && menu_grant == 3'h0)
        else $error("keypad acted under host control");
    lock1_cal_a: assert property ( // [RQ3]
        (is_keys && lock_lvl == LOCK_1 && panel_keys[KEY_CAL]) |=> cmd_cal)
        else $error("cal key lost at lock level one");
    lock2_cal_a: assert property ( // [RQ4]
        (is_keys && lock_lvl == LOCK_2 && menu_req[MENU_BASIC])
            |=> !cmd_cal && menu_refuse[MENU_BASIC])
        else $error("lock two let cal or basic menu through");
    lock3_keys_a: assert property ( // [RQ5]
        (is_keys && lock_lvl == LOCK_3)
            |=> !(cmd_cal || cmd_manual || cmd_zero || key_other))
        else $error("locked key acted at lock level three");
    lock3_vol_a: assert property ( // [RQ6]
        (is_keys && lock_lvl == LOCK_3 && hand_keys[KEY_VOL_UP]) |=> vol_up)
        else $error("volume key lost at lock level three");
    ext_start_a: assert property ( // [RQ9]
        (is_ext && ext.start_rise) |=> cmd_start)
        else $error("start edge not passed on");
    stop_ack_a: assert property ( // [RQ10]
        (stop_rise && err_pending) |=> cmd_ack && !cmd_stop)
        else $error("stop edge did not acknowledge error");
    bg_follow_a: assert property ( // [RQ12] [RQ13]
        is_ext |=> bg_suppress == $past(ext.zero_lvl))
        else $error("suppress output does not follow line");
    vent_never_a: assert property ( // [RQ16]
        (vent_sel == VENT_NEVER && !host_vent) |=> !cmd_vent)
        else $error("vented with no-vent setting");
    vent_early_a: assert property ( // [RQ15]
        (q.st == ST_HOLD && !stop_lvl) |=> !cmd_vent && q.st == ST_IDLE)
        else $error("vented after early release");
    vent_now_a: assert property ( // [RQ14]
        (q.st == ST_IDLE && stop_rise && vent_sel == VENT_NOW) |=> cmd_vent)
        else $error("immediate vent missing");

endmodule

// File: dv/ecs_plant_model.sv
// plant controller model driving the discrete control lines
`timescale 1ns/100ps
module ecs_plant_model (
    input  wire logic core_clk,
    output logic      ext_start_pin,
    output logic      ext_stop_pin,
    output logic      ext_zero_pin
);

    // lines idle low, as an unused input reads
    initial begin
        ext_start_pin = 1'b0;
        ext_stop_pin  = 1'b0;
        ext_zero_pin  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // start request: low-to-high step, held, then dropped for the next edge
    task automatic start_edge();
        @(posedge core_clk) ext_start_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_start_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // stop line high for n cycles; a long hold asks for venting
    task automatic stop_hold(input int n);
        @(posedge core_clk) ext_stop_pin <= 1'b1;
        repeat (n) @(posedge core_clk);
        ext_stop_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // background suppress level
    task automatic set_zero(input logic v);
        @(posedge core_clk) ext_zero_pin <= v;
    endtask
endmodule

// File: dv/tb_control_source_and_ext_inputs.sv
// self-checking bench for control-source selection and discrete inputs
`timescale 1ns/100ps
module tb_control_source_and_ext_inputs;
    import ecs_pkg::*;
    // short vent holds keep the run brief
    localparam logic [CNT_W-1:0] V1    = 25'h0000005;
    localparam logic [CNT_W-1:0] V15   = 25'h0000008;
    localparam logic [CNT_W-1:0] V2    = 25'h000000b;
    localparam logic [15:0]      LIMIT = 16'h4e20;

    logic              core_clk, rst, pwd_ok, err_pending, clr;
    logic              host_start, host_stop, host_zero, host_vent;
    ecs_src_t          src_sel;
    ecs_lock_t         lock_lvl;
    ecs_vent_t         vent_sel;
    logic [KEY_N-1:0]  hand_keys, panel_keys;
    logic [MENU_N-1:0] menu_req, menu_grant, menu_refuse;
    wire logic         ext_start_pin, ext_stop_pin, ext_zero_pin;
    logic              cmd_start, cmd_stop, cmd_ack, cmd_vent, cmd_cal;
    logic              cmd_manual, cmd_zero, vol_up, vol_dn, key_other;
    logic              bg_suppress, stop_held;
    logic [7:0]        seen, n_vent, n_ack, n_held;
    logic [15:0]       cyc, t_stop, t_vent;
    int                err_total, total_checks;

    ecs_ctrl #(.VENT_1_CYC(V1), .VENT_15_CYC(V15), .VENT_2_CYC(V2)) dut_u (
        .core_clk, .rst, .src_sel, .lock_lvl, .vent_sel, .hand_keys,
        .panel_keys, .menu_req, .pwd_ok, .host_start, .host_stop,
        .host_zero, .host_vent, .ext_start_pin, .ext_stop_pin,
        .ext_zero_pin, .err_pending, .cmd_start, .cmd_stop, .cmd_ack,
        .cmd_vent, .cmd_cal, .cmd_manual, .cmd_zero, .vol_up, .vol_dn,
        .key_other, .bg_suppress, .menu_grant, .menu_refuse, .stop_held
    );

    ecs_plant_model plant_u (
        .core_clk, .ext_start_pin, .ext_stop_pin, .ext_zero_pin
    );

    always #50 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // output monitor: pulses seen, vent count, stop/vent moments, timeout
    always @(posedge core_clk) begin
        cyc <= cyc + 16'h0001;
        if (clr) begin
            seen   <= 8'h00;
            n_vent <= 8'h00;
            n_ack  <= 8'h00;
            n_held <= 8'h00;
        end else begin
            seen   <= seen | {key_other, vol_dn, vol_up, cmd_zero,
                              cmd_manual, cmd_cal, cmd_stop, cmd_start};
            n_vent <= n_vent + {7'h00, cmd_vent};
            n_ack  <= n_ack + {7'h00, cmd_ack};
            n_held <= n_held + {7'h00, stop_held};
        end
        if (cmd_stop) t_stop <= cyc;
        if (cmd_vent) t_vent <= cyc;
        if (cyc == LIMIT) begin
            err_total++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // settings change, then monitor cleared
    task automatic setup(input ecs_src_t s, input ecs_lock_t l,
                         input ecs_vent_t v);
        @(posedge core_clk);
        src_sel  <= s;
        lock_lvl <= l;
        vent_sel <= v;
        clr      <= 1'b1;
        @(posedge core_clk) clr <= 1'b0;
    endtask

    // one key at a time on one keypad; only allowed keys give a pulse
    task automatic key_scan(input logic [7:0] mask, input logic panel);
        for (int i = 0; i < KEY_N; i++) begin
            setup(src_sel, lock_lvl, VENT_NEVER);
            @(posedge core_clk);
            if (panel) panel_keys <= 8'h01 << i;
            else hand_keys <= 8'h01 << i;
            @(posedge core_clk);
            panel_keys <= 8'h00;
            hand_keys  <= 8'h00;
            repeat (3) @(posedge core_clk);
            check("key", seen, (8'h01 << i) & mask);
        end
    endtask

    // one menu request; grant and refuse stand for one cycle
    task automatic menu(input logic [2:0] req, input logic pwd,
                        input logic [2:0] eg, input logic [2:0] er);
        @(posedge core_clk);
        menu_req <= req;
        pwd_ok   <= pwd;
        @(posedge core_clk);
        menu_req <= 3'h0;
        pwd_ok   <= 1'b0;
        #1;
        check("grant", {5'h00, menu_grant}, {5'h00, eg});
        check("refuse", {5'h00, menu_refuse}, {5'h00, er});
    endtask

    // external stop held for hold cycles under vent setting v
    task automatic vent_case(input ecs_vent_t v, input int hold,
                             input logic [7:0] en, input logic [7:0] dt,
                             input logic [7:0] eh);
        setup(SRC_EXT, LOCK_1, v);
        plant_u.stop_hold(hold);
        check("stop", seen, err_pending ? 8'h00 : 8'h02);
        check("ack", n_ack, {7'h00, err_pending});
        check("vents", n_vent, en);
        check("held", n_held, eh);
        if (en != 8'h00) begin
            check("vent time", 8'(t_vent - t_stop), dt);
        end
    endtask

    // keypad stop held, same vent timer
    task automatic key_stop(input ecs_vent_t v, input logic [7:0] en);
        setup(SRC_KEYS, LOCK_1, v);
        @(posedge core_clk) hand_keys <= 8'h02;
        repeat (20) @(posedge core_clk);
        hand_keys <= 8'h00;
        repeat (4) @(posedge core_clk);
        check("key vent", n_vent, en);
    endtask

    // one host pulse set {vent, zero, stop, start}
    task automatic host_cmd(input logic [3:0] w, input logic [7:0] es,
                            input logic [7:0] ev);
        setup(src_sel, lock_lvl, VENT_NEVER);
        @(posedge core_clk);
        {host_vent, host_zero, host_stop, host_start} <= w;
        @(posedge core_clk);
        {host_vent, host_zero, host_stop, host_start} <= 4'h0;
        repeat (3) @(posedge core_clk);
        check("host", seen, es);
        check("host vent", n_vent, ev);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        clr = 1'b0;
        cyc = 16'h0000;
        err_total = 0;
        total_checks = 0;
        src_sel = SRC_KEYS;
        lock_lvl = LOCK_1;
        vent_sel = VENT_NEVER;
        {hand_keys, panel_keys} = 16'h0000;
        menu_req = 3'h0;
        {pwd_ok, err_pending} = 2'h0;
        {host_start, host_stop, host_zero, host_vent} = 4'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // keypad lock levels and menus
        setup(SRC_KEYS, LOCK_1, VENT_NEVER);
        key_scan(MASK_L1, 1'b0);
        key_scan(MASK_L1, 1'b1);
        menu(3'h7, 1'b0, 3'h7, 3'h0);
        setup(SRC_KEYS, LOCK_2, VENT_NEVER);
        key_scan(8'hfb, 1'b1);
        menu(3'h1, 1'b1, 3'h0, 3'h1);
        menu(3'h6, 1'b0, 3'h0, 3'h6);
        menu(3'h6, 1'b1, 3'h6, 3'h0);
        setup(SRC_KEYS, LOCK_3, VENT_NEVER);
        key_scan(8'h63, 1'b0);
        menu(3'h7, 1'b1, 3'h6, 3'h1);
        host_cmd(4'hf, 8'h00, 8'h00);
        // host source
        setup(SRC_HOST, LOCK_1, VENT_NEVER);
        key_scan(MASK_NONE, 1'b1);
        menu(3'h7, 1'b1, 3'h0, 3'h7);
        host_cmd(4'h1, 8'h01, 8'h00);
        host_cmd(4'h2, 8'h02, 8'h00);
        host_cmd(4'h4, 8'h10, 8'h00);
        host_cmd(4'h8, 8'h00, 8'h01);
        plant_u.start_edge();
        check("ext ignored", seen, 8'h00);
        // external inputs, then keypad stop venting
        setup(SRC_EXT, LOCK_1, VENT_NEVER);
        plant_u.start_edge();
        check("ext start", seen, 8'h01);
        key_scan(MASK_NONE, 1'b0);
        menu(3'h7, 1'b1, 3'h0, 3'h7);
        err_pending <= 1'b1;
        vent_case(VENT_NEVER, 3, 8'h00, 8'h00, 8'h00);
        err_pending <= 1'b0;
        vent_case(VENT_NOW, 3, 8'h01, 8'h00, 8'h00);
        vent_case(VENT_1S, 20, 8'h01, 8'h05, 8'h05);
        vent_case(VENT_15S, 20, 8'h01, 8'h08, 8'h08);
        vent_case(VENT_2S, 20, 8'h01, 8'h0b, 8'h0b);
        vent_case(VENT_2S, 8, 8'h00, 8'h00, 8'h08);
        vent_case(VENT_NEVER, 30, 8'h00, 8'h00, 8'h00);
        key_stop(VENT_1S, 8'h01);
        key_stop(VENT_NEVER, 8'h00);
        // background suppress level
        setup(SRC_EXT, LOCK_1, VENT_NEVER);
        plant_u.set_zero(1'b1);
        repeat (4) @(posedge core_clk);
        check("suppress on", {7'h00, bg_suppress}, 8'h01);
        plant_u.set_zero(1'b0);
        repeat (4) @(posedge core_clk);
        check("suppress off", {7'h00, bg_suppress}, 8'h00);
        plant_u.set_zero(1'b1);
        setup(SRC_KEYS, LOCK_1, VENT_NEVER);
        repeat (4) @(posedge core_clk);
        check("suppress keys", {7'h00, bg_suppress}, 8'h00);
        final_report();
    end
endmodule
